// ===== hdl/cwq_event_flags.sv
/*
 * cwq_event_flags: per-bundle control-word change flags and host queue
 * threshold flags with masks, one interrupt request, AHB-Lite registers.
 * Assumes control-word updates and queue levels arrive on the packet
 * clock, and one AHB-Lite master with this block as the only slave.
 */
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
module cwq_event_flags
    import cwq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // received control words and queue threshold levels
    input wire cwq_cw_upd_t cwUpd,
    input wire cwq_q_lvl_t qLevel,
    // interrupt request
    output logic irq
);

    logic addrPhase;
    logic dpWrite_r;
    logic dpRead_r;
    logic rdDone_r;
    logic [DEC_W-1:0] dpAddr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rdMux;
    logic wrEn;

    logic [31:0] bMaskLow_r;
    logic [31:0] bMaskHigh_r;
    logic [CW_FIELD_W-1:0] fSel_r;
    logic [QEV_W-1:0] qMask_r;

    logic [CW_FIELD_W-1:0] cwPrev_r [NUM_BUNDLES];
    logic [CW_FIELD_W-1:0] cwSeen_r [NUM_BUNDLES];
    logic [CW_FIELD_W-1:0] cwDiff;
    logic cwChange;
    logic [NUM_BUNDLES-1:0] cwSet;
    logic [NUM_BUNDLES-1:0] cwClr;
    logic [31:0] clrLow;
    logic [31:0] clrHigh;
    logic [31:0] chgLow;
    logic [31:0] chgHigh;
    logic [NUM_BUNDLES-1:0] cwPend;

    cwq_q_lvl_t qPrev_r;
    cwq_q_lvl_t qRise;
    logic [QEV_W-1:0] qSet;
    logic [QEV_W-1:0] qClr;
    logic [QEV_W-1:0] qFlags;
    logic [QEV_W-1:0] qPend;
    logic irq_r;

    // bus slave: writes take no wait state, reads take one so that
    // read data is registered and sees a write just before it
    assign addrPhase = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign hreadyout = !(dpRead_r && !rdDone_r);
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_r;
    assign wrEn = dpWrite_r;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dpWrite_r <= 1'b0;
            dpRead_r <= 1'b0;
            dpAddr_r <= '0;
        end else if (addrPhase) begin
            dpWrite_r <= hwrite;
            dpRead_r <= !hwrite;
            dpAddr_r <= haddr[DEC_W-1:0];
        end else if (hready) begin
            dpWrite_r <= 1'b0;
            dpRead_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdDone_r <= 1'b0;
            hrdata_r <= '0;
        end else begin
            rdDone_r <= dpRead_r && !rdDone_r;
            if (dpRead_r && !rdDone_r) begin
                hrdata_r <= rdMux;
            end
        end
    end

    // unmapped offsets and reserved bits read as zero, except reserved queue mask bits, which read back as written
    always_comb begin
        rdMux = '0;
        case (dpAddr_r)
            ADDR_CHG_LOW: rdMux = chgLow;
            ADDR_BMASK_LOW: rdMux = bMaskLow_r;
            ADDR_CHG_HIGH: rdMux = chgHigh;
            ADDR_BMASK_HIGH: rdMux = bMaskHigh_r;
            ADDR_FSEL: rdMux[CW_FIELD_W-1:0] = fSel_r;
            ADDR_QFLAGS: rdMux[QEV_W-1:0] = qFlags & QE_IMPL;
            ADDR_QMASK: rdMux[QEV_W-1:0] = qMask_r;
            default: rdMux = '0;
        endcase
    end

    // mask registers; reserved queue mask bits are kept as written
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bMaskLow_r <= BMASK_RST;
            bMaskHigh_r <= BMASK_RST;
            fSel_r <= FSEL_RST;
            qMask_r <= QMASK_RST;
        end else if (wrEn) begin
            if (dpAddr_r == ADDR_BMASK_LOW) begin
                bMaskLow_r <= hwdata;
            end
            if (dpAddr_r == ADDR_BMASK_HIGH) begin
                bMaskHigh_r <= hwdata;
            end
            if (dpAddr_r == ADDR_FSEL) begin
                fSel_r <= hwdata[CW_FIELD_W-1:0];
            end
            if (dpAddr_r == ADDR_QMASK) begin
                qMask_r <= hwdata[QEV_W-1:0];
            end
        end
    end

    // flag registers clear by writing ones
    assign clrLow = (wrEn && dpAddr_r == ADDR_CHG_LOW) ? hwdata : '0;
    assign clrHigh = (wrEn && dpAddr_r == ADDR_CHG_HIGH) ? hwdata : '0;
    assign qClr = (wrEn && dpAddr_r == ADDR_QFLAGS) ? hwdata[QEV_W-1:0] : '0;
    assign cwClr = {clrHigh, clrLow};

    // control-word change detection against the last word per bundle
    assign cwDiff = cwUpd.fields ^ cwPrev_r[cwUpd.bundle];
    assign cwChange = cwUpd.valid && (cwDiff != '0);
    assign cwSet = cwChange ? (NUM_BUNDLES'(1) << cwUpd.bundle) : '0;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < NUM_BUNDLES; b++) begin
                cwPrev_r[b] <= '0;
            end
        end else if (cwUpd.valid) begin
            cwPrev_r[cwUpd.bundle] <= cwUpd.fields;
        end
    end

    // which fields changed since the flag was last cleared, so the
    // shared field-select mask can be applied at interrupt time
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int b = 0; b < NUM_BUNDLES; b++) begin
                cwSeen_r[b] <= SEEN_RST;
            end
        end else begin
            for (int b = 0; b < NUM_BUNDLES; b++) begin
                if (cwSet[b]) begin
                    cwSeen_r[b] <= cwClr[b] ? cwDiff : (cwSeen_r[b] | cwDiff);
                end else if (cwClr[b]) begin
                    cwSeen_r[b] <= '0;
                end
            end
        end
    end

    cwq_sticky_flags #(
        .W(HALF_BUNDLES),
        .RST(CHG_RST)
    ) u_chg_low (
        .clock(clock),
        .sys_rst(sys_rst),
        .setVec(cwSet[HALF_BUNDLES-1:0]),
        .clrVec(clrLow),
        .flags(chgLow)
    );

    cwq_sticky_flags #(
        .W(HALF_BUNDLES),
        .RST(CHG_RST)
    ) u_chg_high (
        .clock(clock),
        .sys_rst(sys_rst),
        .setVec(cwSet[NUM_BUNDLES-1:HALF_BUNDLES]),
        .clrVec(clrHigh),
        .flags(chgHigh)
    );

    // queue events fire on the crossing, not the level, so a cleared
    // flag stays clear while the level sits past its threshold
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            qPrev_r <= '0;
        end else begin
            qPrev_r <= qLevel;
        end
    end

    assign qRise = qLevel & ~qPrev_r;

    always_comb begin
        qSet = '0;
        qSet[QE_LINE_POOL] = qRise.lineToHostPoolLow;
        qSet[QE_LINE_QUEUE] = qRise.lineToHostQueueHigh;
        qSet[QE_NET_OUT_QUEUE] = qRise.hostToNetQueueLow;
        qSet[QE_NET_POOL] = qRise.netToHostPoolLow;
        qSet[QE_NET_QUEUE] = qRise.netToHostQueueHigh;
        qSet[QE_LINE_OUT_QUEUE] = qRise.hostToLineQueueHigh;
        qSet[QE_TX_RET] = qRise.txReturnQueueHigh;
        qSet[QE_RX_RET] = qRise.rxReturnQueueHigh;
    end

    cwq_sticky_flags #(
        .W(QEV_W),
        .RST(QFLAG_RST)
    ) u_qflags (
        .clock(clock),
        .sys_rst(sys_rst),
        .setVec(qSet),
        .clrVec(qClr),
        .flags(qFlags)
    );

    // interrupt pending terms
    always_comb begin
        for (int b = 0; b < NUM_BUNDLES; b++) begin
            cwPend[b] = (|(cwSeen_r[b] & ~fSel_r));
        end
        cwPend = cwPend & {chgHigh & ~bMaskHigh_r, chgLow & ~bMaskLow_r};
    end

    assign qPend = qFlags & ~qMask_r & QE_IMPL;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (|cwPend) || (|qPend);
        end
    end

    assign irq = irq_r;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic [4:0] cwIdx;
    logic cwHi;
    logic [CW_FIELD_W-1:0] cwPrevSel;
    assign cwIdx = cwUpd.bundle[4:0];
    assign cwHi = cwUpd.bundle[5];
    assign cwPrevSel = cwPrev_r[cwUpd.bundle];

    sequence s_low_change;
        cwChange && !cwHi;
    endsequence

    sequence s_high_change;
        cwChange && cwHi;
    endsequence

    sequence s_quiet_bus;
        !dpWrite_r [*2];
    endsequence

    property p_low_map;
        s_low_change |=> chgLow[$past(cwIdx)]
            && (chgHigh == ($past(chgHigh) & ~$past(clrHigh)));
    endproperty
    a_low_map: assert property (p_low_map) else $error("low bundle flag not set");

    property p_high_map;
        s_high_change |=> chgHigh[$past(cwIdx)]
            && (chgLow == ($past(chgLow) & ~$past(clrLow)));
    endproperty
    a_high_map: assert property (p_high_map) else $error("high bundle flag not set");

    property p_no_change;
        (cwUpd.valid && cwUpd.fields == cwPrevSel && !dpWrite_r)
            |=> $stable(chgLow) && $stable(chgHigh);
    endproperty
    a_no_change: assert property (p_no_change) else $error("flag set without change");

    property p_fsel_blocks;
        (fSel_r == FSEL_RST && qPend == '0) ##1 (fSel_r == FSEL_RST) |-> !irq_r;
    endproperty
    a_fsel_blocks: assert property (p_fsel_blocks) else $error("masked field raised irq");

    property p_bmask_blocks;
        (bMaskLow_r == BMASK_RST && bMaskHigh_r == BMASK_RST && qPend == '0) |=> !irq_r;
    endproperty
    a_bmask_blocks: assert property (p_bmask_blocks) else $error("masked bundle raised irq");

    property p_q_set;
        (qSet != '0) |=> ((qFlags & $past(qSet)) == $past(qSet));
    endproperty
    a_q_set: assert property (p_q_set) else $error("queue flag not set");

    property p_q_rsvd;
        qFlags[QE_RSVD_HI:QE_RSVD_LO] == '0;
    endproperty
    a_q_rsvd: assert property (p_q_rsvd) else $error("reserved queue flag set");

    property p_q_irq;
        // flag lands one edge after the set, irq one edge after that
        (|(qSet & ~qMask_r)) ##0 s_quiet_bus |=> irq_r;
    endproperty
    a_q_irq: assert property (p_q_irq) else $error("unmasked queue event gave no irq");

    property p_rd_wait;
        (addrPhase && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

endmodule // cwq_event_flags

// ===== hdl/cwq_pkg.sv
/*
 * cwq_pkg: constants and carrier types for the control-word and
 * queue event flag block.
 * Assumes the block decodes the low twelve address bits of its window.
 */
package cwq_pkg;

    localparam int NUM_BUNDLES = 64;
    localparam int HALF_BUNDLES = 32;
    localparam int BUNDLE_W = 6;
    localparam int CW_FIELD_W = 6;
    localparam int QEV_W = 10;
    localparam int DEC_W = 12;

    // register byte offsets
    localparam logic [DEC_W-1:0] ADDR_CHG_LOW = 12'h140;
    localparam logic [DEC_W-1:0] ADDR_BMASK_LOW = 12'h144;
    localparam logic [DEC_W-1:0] ADDR_CHG_HIGH = 12'h148;
    localparam logic [DEC_W-1:0] ADDR_BMASK_HIGH = 12'h14C;
    localparam logic [DEC_W-1:0] ADDR_FSEL = 12'h180;
    localparam logic [DEC_W-1:0] ADDR_QFLAGS = 12'h1C0;
    localparam logic [DEC_W-1:0] ADDR_QMASK = 12'h1C4;

    // control-word field positions, shared by the field-select mask
    localparam int CWF_L = 5;
    localparam int CWF_R = 4;
    localparam int CWF_M_HI = 3;
    localparam int CWF_M_LO = 2;
    localparam int CWF_FRG_HI = 1;
    localparam int CWF_FRG_LO = 0;

    // queue event bit positions
    localparam int QE_LINE_POOL = 9;
    localparam int QE_LINE_QUEUE = 8;
    localparam int QE_NET_OUT_QUEUE = 7;
    localparam int QE_NET_POOL = 6;
    localparam int QE_NET_QUEUE = 5;
    localparam int QE_RSVD_HI = 4;
    localparam int QE_RSVD_LO = 3;
    localparam int QE_LINE_OUT_QUEUE = 2;
    localparam int QE_TX_RET = 1;
    localparam int QE_RX_RET = 0;
    localparam logic [QEV_W-1:0] QE_IMPL = 10'h3E7;

    // reset values
    localparam logic [31:0] CHG_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] BMASK_RST = 32'hFFFF_FFFF;
    localparam logic [CW_FIELD_W-1:0] FSEL_RST = 6'h3F;
    localparam logic [CW_FIELD_W-1:0] SEEN_RST = 6'h3F;
    localparam logic [QEV_W-1:0] QFLAG_RST = 10'h000;
    localparam logic [QEV_W-1:0] QMASK_RST = 10'h3FF;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // fields: [5] L, [4] R, [3:2] M, [1:0] FRG
    typedef struct packed {
        logic valid;
        logic [BUNDLE_W-1:0] bundle;
        logic [CW_FIELD_W-1:0] fields;
    } cwq_cw_upd_t;

    // threshold comparator levels from the queue manager
    typedef struct packed {
        logic lineToHostPoolLow;
        logic lineToHostQueueHigh;
        logic hostToNetQueueLow;
        logic netToHostPoolLow;
        logic netToHostQueueHigh;
        logic hostToLineQueueHigh;
        logic txReturnQueueHigh;
        logic rxReturnQueueHigh;
    } cwq_q_lvl_t;

endpackage

// ===== hdl/cwq_sticky_flags.sv
/*
 * cwq_sticky_flags: bank of sticky event flags, write-one-to-clear.
 * Assumes set and clear vectors come from logic on the same clock.
 */
`timescale 1ns/100ps
module cwq_sticky_flags #(
    parameter int W = 32,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // events and software clears
    input wire logic [W-1:0] setVec,
    input wire logic [W-1:0] clrVec,
    // flag state
    output logic [W-1:0] flags
);

    logic [W-1:0] flags_r;

    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= RST;
        end else begin
            flags_r <= (flags_r & ~clrVec) | setVec;
        end
    end

    assign flags = flags_r;

endmodule // cwq_sticky_flags

// ===== testbench/test_cwq_event_flags.sv
/*
 * test_cwq_event_flags: self-checking bench for the control-word and queue
 * event flag block, driving its AHB-Lite, control-word and queue-level ports.
 * Assumes the package constants and the hand-over latencies of the block.
 */
`timescale 1ns/100ps
module test_cwq_event_flags
    import cwq_pkg::*;
;
    typedef struct {
        string name;
        logic [31:0] val;
    } cwq_note_t;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    wire logic [31:0] hrdata;
    cwq_cw_upd_t cwUpd = '0;
    cwq_q_lvl_t qLevel = '0;
    cwq_note_t notes[$];
    int bad_count = 0;
    int n_compared = 0;
    logic rdPend = 1'b0;
    logic [5:0] lastCw [NUM_BUNDLES];
    int qPos [8] = '{9, 8, 7, 6, 5, 2, 1, 0};
    logic [5:0] grps [4] = '{6'h20, 6'h10, 6'h0C, 6'h03};

    always #4 clock = ~clock;

    cwq_event_flags u_cwq_event_flags (
        .clock(clock),
        .sys_rst(sys_rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .cwUpd(cwUpd),
        .qLevel(qLevel),
        .irq(irq)
    );

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict;
        if (notes.size() != 0) bad_count++;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // read data is judged here, on the edge where the slave says ready
    always @(posedge clock) begin : monitor
        cwq_note_t n;
        if (rdPend && hreadyout === 1'b1) begin
            if (notes.size() == 0) chk("unexpected_read", 32'h0000_0000, 32'h0000_0001);
            else begin
                n = notes.pop_front();
                chk(n.name, n.val, hrdata);
                chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
            end
        end
        if (hsel && htrans == HTRANS_NONSEQ && hreadyout && !hwrite) rdPend <= 1'b1;
        else if (hreadyout === 1'b1) rdPend <= 1'b0;
    end

    task automatic busOp(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {20'h0_0000, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0000_0000;
        do @(posedge clock); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(string name, logic [11:0] a, logic [31:0] exp);
        notes.push_back('{name, exp});
        busOp(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        busOp(1'b1, a, d);
    endtask

    task automatic chkIrq(logic e);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    function automatic logic [11:0] chgAddr(int b);
        return (b < HALF_BUNDLES) ? ADDR_CHG_LOW : ADDR_CHG_HIGH;
    endfunction

    function automatic logic [31:0] bitOf(int b);
        return 32'h0000_0001 << b[4:0];
    endfunction

    task automatic sendCw(int b, logic [5:0] f);
        @(posedge clock);
        cwUpd <= cwq_cw_upd_t'({1'b1, 6'(b), f});
        lastCw[b] = f;
        @(posedge clock);
        cwUpd <= '0;
    endtask

    // flips one bit of the chosen field, then clears the flag again
    task automatic cwStep(int b, logic [5:0] grp, logic [5:0] fsel, logic e);
        wr(ADDR_FSEL, {26'h0, fsel});
        sendCw(b, lastCw[b] ^ (grp & ~(grp << 1)));
        repeat (3) @(posedge clock);
        chkIrq(e);
        rd("cw_change", chgAddr(b), bitOf(b));
        wr(chgAddr(b), bitOf(b));
        repeat (2) @(posedge clock);
        chkIrq(1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        give_verdict;
    end

    initial begin
        int bl [5];
        int b;
        int p;
        logic [31:0] r;
        logic [5:0] f;
        for (int i = 0; i < NUM_BUNDLES; i++) lastCw[i] = 6'h00;
        r = $urandom(32'hadeb);
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rd("chg_low", ADDR_CHG_LOW, CHG_RST);
        rd("mask_low", ADDR_BMASK_LOW, BMASK_RST);
        rd("chg_high", ADDR_CHG_HIGH, CHG_RST);
        rd("mask_high", ADDR_BMASK_HIGH, BMASK_RST);
        rd("fsel", ADDR_FSEL, {26'h0, FSEL_RST});
        rd("qflags", ADDR_QFLAGS, 32'h0000_0000);
        rd("qmask", ADDR_QMASK, {22'h0, QMASK_RST});
        rd("unmapped", 12'h150, 32'h0000_0000);
        chkIrq(1'b0);
        r = $urandom;
        wr(ADDR_BMASK_HIGH, r);
        rd("mask_high_rw", ADDR_BMASK_HIGH, r);
        wr(ADDR_CHG_LOW, 32'hFFFF_FFFF);
        wr(ADDR_CHG_HIGH, 32'hFFFF_FFFF);
        rd("chg_low_clr", ADDR_CHG_LOW, 32'h0000_0000);
        rd("chg_high_clr", ADDR_CHG_HIGH, 32'h0000_0000);
        $display("test registers done");
        // edges of both halves plus one random bundle
        bl = '{0, 31, 32, 63, int'($urandom % 64)};
        for (int i = 0; i < 5; i++) begin
            b = bl[i];
            f = lastCw[b] ^ 6'(($urandom % 63) + 1);
            sendCw(b, f);
            rd("cw_flag", chgAddr(b), bitOf(b));
            wr(chgAddr(b), bitOf(b));
            sendCw(b, f);
            rd("cw_same", chgAddr(b), 32'h0000_0000);
        end
        $display("test bundle_map done");
        wr(ADDR_BMASK_LOW, ~32'h0000_0080);
        wr(ADDR_BMASK_HIGH, ~32'h0000_0100);
        for (int i = 0; i < 2; i++) begin
            b = (i == 0) ? 7 : 40;
            for (int g = 0; g < 4; g++) begin
                cwStep(b, grps[g], grps[g], 1'b0);
                cwStep(b, grps[g], 6'h3F ^ grps[g], 1'b1);
            end
        end
        cwStep(6, 6'h01, 6'h00, 1'b0);
        cwStep(39, 6'h01, 6'h00, 1'b0);
        wr(ADDR_BMASK_LOW, 32'hFFFF_FFFF);
        wr(ADDR_BMASK_HIGH, 32'hFFFF_FFFF);
        cwStep(7, 6'h20, 6'h00, 1'b0);
        cwStep(40, 6'h20, 6'h00, 1'b0);
        $display("test field_select done");
        for (int i = 0; i < 8; i++) begin
            p = qPos[i];
            wr(ADDR_QMASK, ~(32'h0000_0001 << p) & 32'h0000_03E7);
            @(posedge clock);
            qLevel <= cwq_q_lvl_t'(8'h80 >> i);
            repeat (4) @(posedge clock);
            chkIrq(1'b1);
            rd("qflag", ADDR_QFLAGS, 32'h0000_0001 << p);
            wr(ADDR_QFLAGS, 32'h0000_0001 << p);
            rd("qflag_held", ADDR_QFLAGS, 32'h0000_0000);
            chkIrq(1'b0);
            wr(ADDR_QMASK, 32'h0000_03E7);
            @(posedge clock);
            qLevel <= '0;
            @(posedge clock);
            qLevel <= cwq_q_lvl_t'(8'h80 >> i);
            repeat (4) @(posedge clock);
            chkIrq(1'b0);
            rd("qflag_masked", ADDR_QFLAGS, 32'h0000_0001 << p);
            wr(ADDR_QFLAGS, 32'h0000_0001 << p);
            qLevel <= '0;
        end
        $display("test queue_events done");
        @(posedge clock);
        give_verdict;
    end
endmodule // test_cwq_event_flags
